// File: verilog/pioc_cfg.svh
/*
 * Register offsets, reset values and timing counts of the parallel I/O line
 * control block. Assumes a 32-bit register port with byte offsets.
 */
`ifndef PIOC_CFG_SVH
`define PIOC_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PIOC_OFS_OWNER_ENABLE 8'h00
`define PIOC_OFS_OWNER_DISABLE 8'h04
`define PIOC_OFS_OWNER_STATUS 8'h08
`define PIOC_OFS_OE_SET 8'h10
`define PIOC_OFS_OE_CLEAR 8'h14
`define PIOC_OFS_OE_STATUS 8'h18
`define PIOC_OFS_GF_SET 8'h20
`define PIOC_OFS_GF_CLEAR 8'h24
`define PIOC_OFS_GF_STATUS 8'h28
`define PIOC_OFS_OD_SET 8'h30
`define PIOC_OFS_OD_CLEAR 8'h34
`define PIOC_OFS_OD_STATUS 8'h38
`define PIOC_OFS_PIN_LEVEL 8'h3C

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PIOC_RST_OWNER 32'h3DFF_FFFF
`define PIOC_RST_ZERO 32'h0000_0000

// ----------------------------------------------------------------
// Glitch filter: a level must hold this many cycles to pass
// ----------------------------------------------------------------
`define PIOC_FILTER_CYCLES 2'h2

`endif

// File: verilog/pioc_pkg.sv
/*
 * Types of the parallel I/O line control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pioc_pkg;
	typedef logic [31:0] pioc_word_t;
	typedef logic [7:0] pioc_addr_t;
endpackage

// File: verilog/pioc_filter.sv
/*
 * Per-line glitch filter: two-stage synchroniser, then a level that must stay
 * stable for a set number of cycles before it is passed on when selected.
 * Assumes a raw pin level from outside the clock domain.
 */
`timescale 1ns/1ps
`include "pioc_cfg.svh"

module pioc_filter (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic raw_i,
	input wire logic select_i,
	output logic level_o
);
	logic sync_a;
	logic sync_b;
	logic stable;
	logic [1:0] count;

	// ----------------------------------------------------------------
	// Synchroniser; only sync_b reads sync_a
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync_a <= 1'h0;
			sync_b <= 1'h0;
		end else begin
			sync_a <= raw_i;
			sync_b <= sync_a;
		end
	end

	// ----------------------------------------------------------------
	// Stability counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count <= 2'h0;
			stable <= 1'h0;
		end else if (sync_b == stable) begin
			count <= 2'h0;
		end else if (count == `PIOC_FILTER_CYCLES - 2'h1) begin
			count <= 2'h0;
			stable <= sync_b;
		end else begin
			count <= count + 2'h1;
		end
	end

	// Filter choice also steers the peripheral's view
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			level_o <= 1'h0;
		end else begin
			level_o <= select_i ? stable : sync_b;
		end
	end
endmodule

// File: verilog/pioc_top.sv
/*
 * 32-line parallel I/O port: line ownership, output enable, glitch filter,
 * output data latches and pin level, reached over a simple register port.
 * Assumes single-cycle strobes from a master on CLK_SYS_I and pads that
 * resolve the pin level from the output and enable signals.
 */
// Summary of operation
// - Owner enable/disable writes set/clear port ownership
// - Owned line holds peripheral input at zero
// - Owner status reports ownership, updates on writes
// - Status one means port controls line
// - Output enable set write sets enables
// - Enables recorded even while peripheral drives
// - Output enable clear write clears enables
// - Output enable status reads enables, resets zero
// - Filter set selects filter, any owner
// - Filter clear write deselects filter
// - Filter status reads selection; filter feeds both
// - Data set write sets output latches
// - Data clear write clears output latches
// - Latch drives pin only if owned and enabled
// - Data status reads latches, resets zero
// - Pin level reads pin after synchroniser and filter, three or more cycles late
`timescale 1ns/1ps
`include "pioc_cfg.svh"

module pioc_top (
	input wire logic CLK_SYS_I,
	input wire logic RESET_N_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [31:0] RDATA_O,
	input wire logic [31:0] PAD_IN_I,
	output logic [31:0] PAD_OUT_O,
	output logic [31:0] PAD_OE_O,
	input wire logic [31:0] PERIPH_OUT_I,
	input wire logic [31:0] PERIPH_OE_I,
	output logic [31:0] PERIPH_IN_O
);
	pioc_pkg::pioc_word_t owner;
	pioc_pkg::pioc_word_t out_enable;
	pioc_pkg::pioc_word_t filter_sel;
	pioc_pkg::pioc_word_t out_data;
	pioc_pkg::pioc_word_t pin_level;
	pioc_pkg::pioc_word_t next_rdata;

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	logic wr_owner_en;
	logic wr_owner_dis;
	logic wr_oe_set;
	logic wr_oe_clr;
	logic wr_gf_set;
	logic wr_gf_clr;
	logic wr_od_set;
	logic wr_od_clr;

	assign wr_owner_en = WR_I && (ADDR_I == `PIOC_OFS_OWNER_ENABLE);
	assign wr_owner_dis = WR_I && (ADDR_I == `PIOC_OFS_OWNER_DISABLE);
	assign wr_oe_set = WR_I && (ADDR_I == `PIOC_OFS_OE_SET);
	assign wr_oe_clr = WR_I && (ADDR_I == `PIOC_OFS_OE_CLEAR);
	assign wr_gf_set = WR_I && (ADDR_I == `PIOC_OFS_GF_SET);
	assign wr_gf_clr = WR_I && (ADDR_I == `PIOC_OFS_GF_CLEAR);
	assign wr_od_set = WR_I && (ADDR_I == `PIOC_OFS_OD_SET);
	assign wr_od_clr = WR_I && (ADDR_I == `PIOC_OFS_OD_CLEAR);

	// ----------------------------------------------------------------
	// Control state
	// ----------------------------------------------------------------
	// Zero bits leave state alone, so no read-modify-write is needed
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			owner <= `PIOC_RST_OWNER;
		end else if (wr_owner_en) begin
			owner <= owner | WDATA_I;
		end else if (wr_owner_dis) begin
			owner <= owner & ~WDATA_I;
		end
	end

	// Recorded regardless of ownership; takes effect when owned
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			out_enable <= `PIOC_RST_ZERO;
		end else if (wr_oe_set) begin
			out_enable <= out_enable | WDATA_I;
		end else if (wr_oe_clr) begin
			out_enable <= out_enable & ~WDATA_I;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			filter_sel <= `PIOC_RST_ZERO;
		end else if (wr_gf_set) begin
			filter_sel <= filter_sel | WDATA_I;
		end else if (wr_gf_clr) begin
			filter_sel <= filter_sel & ~WDATA_I;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			out_data <= `PIOC_RST_ZERO;
		end else if (wr_od_set) begin
			out_data <= out_data | WDATA_I;
		end else if (wr_od_clr) begin
			out_data <= out_data & ~WDATA_I;
		end
	end

	// ----------------------------------------------------------------
	// Input path per line
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 32; g = g + 1) begin : g_line
			pioc_filter u_filter (
				.clk_i(CLK_SYS_I),
				.reset_n_i(RESET_N_I),
				.raw_i(PAD_IN_I[g]),
				.select_i(filter_sel[g]),
				.level_o(pin_level[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pad and peripheral outputs
	// ----------------------------------------------------------------
	// Registered to keep every top output flop-driven; costs one cycle
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			PAD_OUT_O <= `PIOC_RST_ZERO;
			PAD_OE_O <= `PIOC_RST_ZERO;
		end else begin
			PAD_OE_O <= (owner & out_enable) | (~owner & PERIPH_OE_I);
			PAD_OUT_O <= (owner & out_data) | (~owner & PERIPH_OUT_I);
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			PERIPH_IN_O <= `PIOC_RST_ZERO;
		end else begin
			PERIPH_IN_O <= pin_level & ~owner;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = `PIOC_RST_ZERO;
		unique case (ADDR_I)
			`PIOC_OFS_OWNER_STATUS: next_rdata = owner;
			`PIOC_OFS_OE_STATUS: next_rdata = out_enable;
			`PIOC_OFS_GF_STATUS: next_rdata = filter_sel;
			`PIOC_OFS_OD_STATUS: next_rdata = out_data;
			`PIOC_OFS_PIN_LEVEL: next_rdata = pin_level;
			default: next_rdata = `PIOC_RST_ZERO;
		endcase
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			RDATA_O <= `PIOC_RST_ZERO;
		end else if (RD_I) begin
			RDATA_O <= next_rdata;
		end else begin
			RDATA_O <= `PIOC_RST_ZERO;
		end
	end
endmodule

// File: tb/pioc_sva.sv
/* Checker of the pioc_top ports, with a shadow of the line registers.
   Assumes one clock, an async low reset, and reads never beside writes. */
`timescale 1ns/1ps
module pioc_sva (
	input wire logic CLK_SYS_I,
	input wire logic RESET_N_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [31:0] RDATA_O,
	input wire logic [31:0] PAD_IN_I,
	input wire logic [31:0] PAD_OUT_O,
	input wire logic [31:0] PAD_OE_O,
	input wire logic [31:0] PERIPH_OUT_I,
	input wire logic [31:0] PERIPH_OE_I,
	input wire logic [31:0] PERIPH_IN_O
);
	// --------
	// Shadow
	// --------
	logic [31:0] own, oe, gf, od, exp_rd;
	logic live;
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			{live, own, oe, gf, od} <= {1'h0, 32'h3DFF_FFFF, 96'h0};
		end else begin
			live <= 1'h1;
			if (WR_I) begin
				case (ADDR_I)
				8'h00: own <= own | WDATA_I;
				8'h04: own <= own & ~WDATA_I;
				8'h10: oe <= oe | WDATA_I;
				8'h14: oe <= oe & ~WDATA_I;
				8'h20: gf <= gf | WDATA_I;
				8'h24: gf <= gf & ~WDATA_I;
				8'h30: od <= od | WDATA_I;
				8'h34: od <= od & ~WDATA_I;
				default: ;
				endcase
			end
		end
	end
	always_comb begin
		case (ADDR_I)
		8'h08: exp_rd = own;
		8'h18: exp_rd = oe;
		8'h28: exp_rd = gf;
		8'h38: exp_rd = od;
		default: exp_rd = 32'h0;
		endcase
	end
	// --------
	// Checks
	// --------
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RESET_N_I);
	chk_pad_enable: assert property (live |-> PAD_OE_O == $past(own & oe | ~own & PERIPH_OE_I))
		else $error("pad enable wrong");
	chk_pad_data: assert property (live |-> PAD_OUT_O == $past(own & od | ~own & PERIPH_OUT_I))
		else $error("pad data wrong");
	chk_read_data: assert property (RD_I && ADDR_I != 8'h3C |=> RDATA_O == $past(exp_rd))
		else $error("read data wrong");
	chk_rdata_idle: assert property (!RD_I |=> RDATA_O == 32'h0)
		else $error("read data not idle");
	chk_periph_zero: assert property (live |-> (PERIPH_IN_O & $past(own)) == 32'h0)
		else $error("owned line reaches peripheral");
	chk_pin_level: assert property ($stable(PAD_IN_I)[*6] ##0 (RD_I && ADDR_I == 8'h3C)
		|=> RDATA_O == $past(PAD_IN_I))
		else $error("pin level wrong");
	chk_pin_fast: assert property ($stable(PAD_IN_I)[*4] ##0 (RD_I && ADDR_I == 8'h3C
		&& gf == 32'h0 && $past(gf, 4) == 32'h0) |=> RDATA_O == $past(PAD_IN_I))
		else $error("unfiltered pin slow");
	chk_periph_level: assert property ($stable(PAD_IN_I)[*7]
		|-> (PERIPH_IN_O & ~$past(own)) == (PAD_IN_I & ~$past(own)))
		else $error("peripheral input wrong");
	cov_release: cover property (WR_I && ADDR_I == 8'h04 && WDATA_I != 32'h0);
	cov_pin_read: cover property (RD_I && ADDR_I == 8'h3C);
	cov_hole_read: cover property (RD_I && ADDR_I == 8'h0C);
endmodule
bind pioc_top pioc_sva u_sva (.*);

// File: tb/pioc_pads.sv
/* Board model of the 32 pads.
   Assumes pioc_top pad outputs and an outside source on every line. */
`timescale 1ns/1ps
module pioc_pads (
	input wire logic [31:0] pad_out_i,
	input wire logic [31:0] pad_oe_i,
	input wire logic [31:0] ext_i,
	output logic [31:0] pin_o
);
	// Released lines follow the outside source, never a stale chip drive
	assign pin_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule

// File: tb/parallel_io_line_control_test.sv
/* Testbench of pioc_top: register tasks and one task per scenario.
   Assumes pioc_sva is bound and pioc_pads closes the pad loop. */
`timescale 1ns/1ps
module parallel_io_line_control_test;
	logic clk, rst_n, wr, rd;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, pad_in, pad_out, pad_oe, p_out, p_oe, p_in, ext;
	int errors, tests_run;
	pioc_top u_dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PAD_IN_I(pad_in), .PAD_OUT_O(pad_out),
		.PAD_OE_O(pad_oe), .PERIPH_OUT_I(p_out), .PERIPH_OE_I(p_oe), .PERIPH_IN_O(p_in));
	pioc_pads u_pads (.pad_out_i(pad_out), .pad_oe_i(pad_oe), .ext_i(ext), .pin_o(pad_in));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{wr, addr, wdata} <= {1'h1, a, d};
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		{rd, addr} <= {1'h1, a};
		@(posedge clk);
		rd <= 1'h0;
		#1 cmp("rdata", e, rdata);
	endtask
	task automatic t_reset();
		wr_reg(8'h08, 32'hFFFF_FFFF);
		rd_reg(8'h08, 32'h3DFF_FFFF);
		rd_reg(8'h18, 32'h0);
		rd_reg(8'h28, 32'h0);
		rd_reg(8'h38, 32'h0);
		rd_reg(8'h0C, 32'h0);
	endtask
	task automatic t_own();
		wr_reg(8'h10, 32'h0200_0000);
		// Pad outputs lag the register state by one cycle
		@(posedge clk);
		#1 cmp("pad_oe", 32'h0, pad_oe);
		rd_reg(8'h18, 32'h0200_0000);
		wr_reg(8'h00, 32'h0200_0000);
		@(posedge clk);
		#1 cmp("pad_oe", 32'h0200_0000, pad_oe);
		rd_reg(8'h08, 32'h3FFF_FFFF);
		wr_reg(8'h14, 32'h0200_0000);
		rd_reg(8'h18, 32'h0);
		wr_reg(8'h04, 32'h0200_0000);
		rd_reg(8'h08, 32'h3DFF_FFFF);
	endtask
	task automatic t_data();
		wr_reg(8'h30, 32'hFFFF_0000);
		wr_reg(8'h34, 32'h0F00_0000);
		@(posedge clk);
		#1 cmp("pad_out", 32'h30FF_0000, pad_out);
		wr_reg(8'h30, 32'h0);
		rd_reg(8'h38, 32'hF0FF_0000);
		wr_reg(8'h10, 32'hFFFF_FFFF);
		repeat (8) @(posedge clk);
		rd_reg(8'h3C, 32'h30FF_0000);
		wr_reg(8'h14, 32'hFFFF_FFFF);
		wr_reg(8'h34, 32'hFFFF_FFFF);
		rd_reg(8'h38, 32'h0);
	endtask
	task automatic t_filt();
		wr_reg(8'h20, 32'h0000_00FF);
		rd_reg(8'h28, 32'h0000_00FF);
		wr_reg(8'h24, 32'h0000_000F);
		rd_reg(8'h28, 32'h0000_00F0);
		// Line 30 stays with its peripheral, which drives it high
		@(posedge clk);
		{ext, p_out, p_oe} <= {32'h0200_00AA, 32'h4000_0000, 32'h4000_0000};
		repeat (8) @(posedge clk);
		rd_reg(8'h3C, 32'h4200_00AA);
		cmp("periph_in", 32'h4200_0000, p_in);
		cmp("pad_out", 32'h4000_0000, pad_out);
		cmp("pad_oe", 32'h4000_0000, pad_oe);
		// Filtered lines 4 to 7 must lag the unfiltered ones by two cycles
		@(posedge clk);
		ext <= 32'h0200_0055;
		repeat (2) @(posedge clk);
		rd_reg(8'h3C, 32'h4200_00A5);
		repeat (4) @(posedge clk);
		rd_reg(8'h3C, 32'h4200_0055);
	endtask
	task automatic print_verdict();
		if (errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		{wr, rd, addr, wdata, p_out, p_oe, ext} = '0;
		{errors, tests_run} = '0;
		rst_n = 1'h0;
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		t_reset();
		t_own();
		t_data();
		t_filt();
		// Reset in mid-run must restore every register
		@(posedge clk);
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		t_reset();
		print_verdict();
	end
	initial begin
		#1_000_000;
		errors++;
		print_verdict();
	end
endmodule
